// file: hw/fsc_consts.svh
// named constants of the flash status controller: offsets, fields, codes, times
// assumes the includer compiles it once per unit; definitions only
`ifndef FSC_CONSTS_SVH
`define FSC_CONSTS_SVH

// ---------------------------------------------------------------
// register byte offsets on the bus
// ---------------------------------------------------------------
`define FSC_OFF_CTRL 8'h00
`define FSC_OFF_ADDR 8'h04
`define FSC_OFF_WDATA 8'h08
`define FSC_OFF_RDATA 8'h0C
`define FSC_OFF_STATUS 8'h10

// ---------------------------------------------------------------
// operation codes in the control register, bits [2:0]
// ---------------------------------------------------------------
`define FSC_OP_READ 3'h1
`define FSC_OP_WRITE 3'h2
`define FSC_OP_POLL 3'h3
`define FSC_OP_ERASE_ADD 3'h4
`define FSC_OP_ABORT 3'h5

// ---------------------------------------------------------------
// result codes in the status register, bits [3:1]
// ---------------------------------------------------------------
`define FSC_RES_NONE 3'h0
`define FSC_RES_PASS 3'h1
`define FSC_RES_FAIL 3'h2
`define FSC_RES_REJECT 3'h3
`define FSC_RES_DONE 3'h4
`define FSC_RES_ABORT 3'h5

// ---------------------------------------------------------------
// status bit positions on the flash data pins and flash commands
// ---------------------------------------------------------------
`define FSC_BIT_TB1 6
`define FSC_BIT_TL 5
`define FSC_BIT_ET 3
`define FSC_BIT_TB2 2
`define FSC_CMD_RESET 16'h00F0
`define FSC_CMD_SECT_ERASE 16'h0030

// ---------------------------------------------------------------
// times in ns and the clock period
// ---------------------------------------------------------------
`define FSC_CLK_NS 4
`define FSC_T_ACC_NS 120
`define FSC_T_WP_NS 50
`define FSC_T_REC_NS 30

`endif

// file: hw/fsc_ctrl.sv
// flash status controller: AHB-Lite register slave driving a NOR flash
// assumes one clock, pins from the flash synchronised here, zero-wait bus
`timescale 1ns/1ps
`include "fsc_consts.svh"

module fsc_ctrl #(
	parameter int AW = 18,
	parameter int DW = 16
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// ahb-lite slave
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	// flash pins
	input wire logic [DW-1:0] i_dq,
	input wire logic i_ready_busy_n_out,
	output logic [AW-1:0] o_addr,
	output logic [DW-1:0] o_dq,
	output logic o_dq_oe_n,
	output logic o_ce_n,
	output logic o_oe_n,
	output logic o_we_n
);

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	logic [DW-1:0] dq_sync;
	logic rdy_sync;

	fsc_sync #(.W(DW + 1)) u_sync (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_d({i_ready_busy_n_out, i_dq}),
		.o_q({rdy_sync, dq_sync})
	);

	// ---------------------------------------------------------------
	// bus slave
	// ---------------------------------------------------------------
	logic addr_ph;
	logic wr_pend_reg;
	logic [7:0] wr_off_reg;
	logic ctrl_wr;
	logic [2:0] ctrl_op;
	logic [AW-1:0] addr_reg;
	logic [DW-1:0] wdata_reg;
	logic [DW-1:0] rdata_reg;
	logic [2:0] result_reg;
	logic tb1_tog_reg;
	logic tb2_tog_reg;
	logic tl_seen_reg;
	logic et_before_reg;
	logic et_after_reg;
	logic abort_reg;
	logic busy;
	logic [31:0] status_word;
	fsc_pkg::fsc_seq_t state_reg;

	// single word transfers only, so hsize needs no lane logic
	assign addr_ph = i_hsel && i_htrans[1] && i_hready;
	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;
	assign busy = (state_reg != fsc_pkg::FSC_S_IDLE);
	assign ctrl_wr = wr_pend_reg && (wr_off_reg == `FSC_OFF_CTRL);
	assign ctrl_op = i_hwdata[2:0];
	// ready/busy shown as seen at the pin, high means ready
	assign status_word = {22'h000000, et_after_reg, et_before_reg, tl_seen_reg,
		tb2_tog_reg, tb1_tog_reg, rdy_sync, result_reg, busy};

	// address phase capture for the write data phase
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_pend_reg <= 1'b0;
			wr_off_reg <= 8'h00;
		end else begin
			wr_pend_reg <= addr_ph && i_hwrite;
			wr_off_reg <= i_haddr[7:0];
		end
	end

	// read data registered at the address phase, unmapped reads give zero
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_hrdata <= 32'h00000000;
		end else if (addr_ph && !i_hwrite) begin
			case (i_haddr[7:0])
				`FSC_OFF_ADDR: o_hrdata <= 32'(addr_reg);
				`FSC_OFF_WDATA: o_hrdata <= 32'(wdata_reg);
				`FSC_OFF_RDATA: o_hrdata <= 32'(rdata_reg);
				`FSC_OFF_STATUS: o_hrdata <= status_word;
				default: o_hrdata <= 32'h00000000;
			endcase
		end
	end

	// address and write data registers
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			addr_reg <= '0;
			wdata_reg <= '0;
		end else if (wr_pend_reg && !busy) begin
			if (wr_off_reg == `FSC_OFF_ADDR) begin
				addr_reg <= i_hwdata[AW-1:0];
			end
			if (wr_off_reg == `FSC_OFF_WDATA) begin
				wdata_reg <= i_hwdata[DW-1:0];
			end
		end
	end

	// ---------------------------------------------------------------
	// pin cycle engine
	// ---------------------------------------------------------------
	logic launched_reg;
	logic cyc_start;
	logic cyc_write;
	logic [DW-1:0] cyc_wdata;
	logic cyc_done;
	logic [DW-1:0] cyc_rdata;
	logic op_wr_reg;

	assign cyc_start = busy && !launched_reg;

	// what each state puts on the pins; status reads use addr_reg
	always_comb begin
		cyc_write = 1'b0;
		cyc_wdata = wdata_reg;
		case (state_reg)
			fsc_pkg::FSC_S_XFER: cyc_write = op_wr_reg;
			fsc_pkg::FSC_S_RESET: begin
				cyc_write = 1'b1;
				cyc_wdata = `FSC_CMD_RESET;
			end
			fsc_pkg::FSC_S_ERASE: begin
				cyc_write = 1'b1;
				cyc_wdata = `FSC_CMD_SECT_ERASE;
			end
			default: cyc_write = 1'b0;
		endcase
	end

	fsc_flash_cycle #(.AW(AW), .DW(DW)) u_cyc (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_start(cyc_start),
		.i_write(cyc_write),
		.i_addr(addr_reg), // status reads at software's status address
		.i_wdata(cyc_wdata),
		.o_done(cyc_done),
		.o_rdata(cyc_rdata),
		.i_dq(dq_sync),
		.o_addr(o_addr),
		.o_dq(o_dq),
		.o_dq_oe_n(o_dq_oe_n),
		.o_ce_n(o_ce_n),
		.o_oe_n(o_oe_n),
		.o_we_n(o_we_n)
	);

	// one launch per state visit
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			launched_reg <= 1'b0;
		end else if (cyc_done) begin
			launched_reg <= 1'b0;
		end else if (cyc_start) begin
			launched_reg <= 1'b1;
		end
	end

	// abort request; honoured only between cycles so no strobe is cut short
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			abort_reg <= 1'b0;
		end else if (!busy) begin
			abort_reg <= 1'b0;
		end else if (ctrl_wr && ctrl_op == `FSC_OP_ABORT) begin
			abort_reg <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// sequencer
	// ---------------------------------------------------------------
	logic [DW-1:0] first_reg;
	logic tb1_same;

	assign tb1_same = (cyc_rdata[`FSC_BIT_TB1] == first_reg[`FSC_BIT_TB1]);

	// every poll starts at the first double read
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg <= fsc_pkg::FSC_S_IDLE;
			op_wr_reg <= 1'b0;
			first_reg <= '0;
			rdata_reg <= '0;
			result_reg <= `FSC_RES_NONE;
			tb1_tog_reg <= 1'b0;
			tb2_tog_reg <= 1'b0;
			tl_seen_reg <= 1'b0;
			et_before_reg <= 1'b0;
			et_after_reg <= 1'b0;
		end else begin
			case (state_reg)
				fsc_pkg::FSC_S_IDLE: begin
					if (ctrl_wr) begin
						case (ctrl_op)
							`FSC_OP_READ, `FSC_OP_WRITE: begin
								op_wr_reg <= (ctrl_op == `FSC_OP_WRITE);
								result_reg <= `FSC_RES_NONE;
								state_reg <= fsc_pkg::FSC_S_XFER;
							end
							`FSC_OP_POLL: begin
								result_reg <= `FSC_RES_NONE;
								tl_seen_reg <= 1'b0;
								state_reg <= fsc_pkg::FSC_S_RD1;
							end
							`FSC_OP_ERASE_ADD: begin
								result_reg <= `FSC_RES_NONE;
								state_reg <= fsc_pkg::FSC_S_PRE;
							end
							default: state_reg <= fsc_pkg::FSC_S_IDLE;
						endcase
					end
				end
				fsc_pkg::FSC_S_XFER: begin
					if (cyc_done) begin
						if (!op_wr_reg) begin
							rdata_reg <= cyc_rdata;
						end
						result_reg <= `FSC_RES_DONE;
						state_reg <= fsc_pkg::FSC_S_IDLE;
					end
				end
				fsc_pkg::FSC_S_RD1, fsc_pkg::FSC_S_RD3: begin
					if (cyc_done) begin
						first_reg <= cyc_rdata;
						state_reg <= (state_reg == fsc_pkg::FSC_S_RD1) ?
							fsc_pkg::FSC_S_RD2 : fsc_pkg::FSC_S_RD4;
					end
				end
				fsc_pkg::FSC_S_RD2: begin
					if (cyc_done) begin
						rdata_reg <= cyc_rdata;
						tb1_tog_reg <= !tb1_same;
						// erase-sector reads show toggle bit two moving
						tb2_tog_reg <= cyc_rdata[`FSC_BIT_TB2] != first_reg[`FSC_BIT_TB2];
						if (tb1_same) begin
							result_reg <= `FSC_RES_PASS;
							state_reg <= fsc_pkg::FSC_S_IDLE;
						end else if (cyc_rdata[`FSC_BIT_TL]) begin
							tl_seen_reg <= 1'b1;
							state_reg <= fsc_pkg::FSC_S_RD3;
						end else if (abort_reg) begin
							result_reg <= `FSC_RES_ABORT;
							state_reg <= fsc_pkg::FSC_S_IDLE;
						end else begin
							state_reg <= fsc_pkg::FSC_S_RD1;
						end
					end
				end
				fsc_pkg::FSC_S_RD4: begin
					if (cyc_done) begin
						rdata_reg <= cyc_rdata;
						tb1_tog_reg <= !tb1_same;
						if (tb1_same) begin
							result_reg <= `FSC_RES_PASS;
							state_reg <= fsc_pkg::FSC_S_IDLE;
						end else begin
							state_reg <= fsc_pkg::FSC_S_RESET;
						end
					end
				end
				fsc_pkg::FSC_S_RESET: begin
					if (cyc_done) begin
						result_reg <= `FSC_RES_FAIL;
						state_reg <= fsc_pkg::FSC_S_IDLE;
					end
				end
				fsc_pkg::FSC_S_PRE: begin
					if (cyc_done) begin
						et_before_reg <= cyc_rdata[`FSC_BIT_ET]; // always checked
						et_after_reg <= 1'b0;
						if (cyc_rdata[`FSC_BIT_ET]) begin
							// window already closed: the flash would ignore it
							result_reg <= `FSC_RES_REJECT;
							state_reg <= fsc_pkg::FSC_S_IDLE;
						end else begin
							state_reg <= fsc_pkg::FSC_S_ERASE;
						end
					end
				end
				fsc_pkg::FSC_S_ERASE: begin
					if (cyc_done) begin
						state_reg <= fsc_pkg::FSC_S_POST;
					end
				end
				fsc_pkg::FSC_S_POST: begin
					if (cyc_done) begin
						et_after_reg <= cyc_rdata[`FSC_BIT_ET];
						result_reg <= cyc_rdata[`FSC_BIT_ET] ? `FSC_RES_REJECT : `FSC_RES_PASS;
						state_reg <= fsc_pkg::FSC_S_IDLE;
					end
				end
				default: begin
					state_reg <= fsc_pkg::FSC_S_IDLE;
				end
			endcase
		end
	end

endmodule

// file: hw/fsc_flash_cycle.sv
// one read or write cycle on the flash strobe pins
// assumes i_dq is already synchronised and start comes only while idle
`timescale 1ns/1ps
`include "fsc_consts.svh"

module fsc_flash_cycle #(
	parameter int AW = 18,
	parameter int DW = 16
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// request from the sequencer
	input wire logic i_start,
	input wire logic i_write,
	input wire logic [AW-1:0] i_addr,
	input wire logic [DW-1:0] i_wdata,
	output logic o_done,
	output logic [DW-1:0] o_rdata,
	// flash pins
	input wire logic [DW-1:0] i_dq,
	output logic [AW-1:0] o_addr,
	output logic [DW-1:0] o_dq,
	output logic o_dq_oe_n,
	output logic o_ce_n,
	output logic o_oe_n,
	output logic o_we_n
);

	// read strobe covers access time plus the two synchroniser stages
	localparam int ACC_CYC = (`FSC_T_ACC_NS + `FSC_CLK_NS - 1) / `FSC_CLK_NS + 2;
	localparam int WP_CYC = (`FSC_T_WP_NS + `FSC_CLK_NS - 1) / `FSC_CLK_NS;
	localparam int REC_CYC = (`FSC_T_REC_NS + `FSC_CLK_NS - 1) / `FSC_CLK_NS;

	fsc_pkg::fsc_cyc_t state_reg;
	logic [7:0] cnt_reg;
	logic write_reg;

	// strobe timing; every read is a separate OE cycle so toggle bits advance
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg <= fsc_pkg::FSC_C_IDLE;
			cnt_reg <= 8'h00;
			write_reg <= 1'b0;
			o_done <= 1'b0;
			o_rdata <= '0;
			o_addr <= '0;
			o_dq <= '0;
			o_dq_oe_n <= 1'b1;
			o_ce_n <= 1'b1;
			o_oe_n <= 1'b1;
			o_we_n <= 1'b1;
		end else begin
			o_done <= 1'b0;
			case (state_reg)
				fsc_pkg::FSC_C_IDLE: begin
					if (i_start) begin
						write_reg <= i_write;
						o_addr <= i_addr;
						o_dq <= i_wdata;
						o_dq_oe_n <= !i_write;
						o_ce_n <= 1'b0;
						o_oe_n <= i_write;
						o_we_n <= !i_write;
						cnt_reg <= i_write ? 8'(WP_CYC - 1) : 8'(ACC_CYC - 1);
						state_reg <= fsc_pkg::FSC_C_STROBE;
					end
				end
				fsc_pkg::FSC_C_STROBE: begin
					if (cnt_reg == 8'h00) begin
						if (!write_reg) begin
							o_rdata <= i_dq;
						end
						// rising write strobe latches the data; data held into recovery
						o_ce_n <= 1'b1;
						o_oe_n <= 1'b1;
						o_we_n <= 1'b1;
						cnt_reg <= 8'(REC_CYC - 1);
						state_reg <= fsc_pkg::FSC_C_HOLD;
					end else begin
						cnt_reg <= cnt_reg - 8'h01;
					end
				end
				fsc_pkg::FSC_C_HOLD: begin
					if (cnt_reg == 8'h00) begin
						o_dq_oe_n <= 1'b1;
						o_done <= 1'b1;
						state_reg <= fsc_pkg::FSC_C_IDLE;
					end else begin
						cnt_reg <= cnt_reg - 8'h01;
					end
				end
				default: begin
					state_reg <= fsc_pkg::FSC_C_IDLE;
				end
			endcase
		end
	end

endmodule

// file: hw/fsc_pkg.sv
// types of the flash status controller
// assumes fsc_consts.svh holds the numbers; this package holds only types
package fsc_pkg;

	// sequencer states, one-hot
	typedef enum logic [9:0] {
		FSC_S_IDLE = 10'h001,
		FSC_S_XFER = 10'h002,
		FSC_S_RD1 = 10'h004,
		FSC_S_RD2 = 10'h008,
		FSC_S_RD3 = 10'h010,
		FSC_S_RD4 = 10'h020,
		FSC_S_RESET = 10'h040,
		FSC_S_PRE = 10'h080,
		FSC_S_ERASE = 10'h100,
		FSC_S_POST = 10'h200
	} fsc_seq_t;

	// pin cycle states, one-hot
	typedef enum logic [2:0] {
		FSC_C_IDLE = 3'h1,
		FSC_C_STROBE = 3'h2,
		FSC_C_HOLD = 3'h4
	} fsc_cyc_t;

endpackage

// file: hw/fsc_sync.sv
// two-flop synchroniser for pins that arrive from outside the clock domain
// assumes the inputs are quasi-static across the sampled window
`timescale 1ns/1ps

module fsc_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// pins in, synchronised out
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);

	logic [W-1:0] meta_reg;

	// first stage feeds only the second stage
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_reg <= '0;
			o_q <= '0;
		end else begin
			meta_reg <= i_d;
			o_q <= meta_reg;
		end
	end

endmodule

// file: tb/fsc_ctrl_assertions.sv
// port checker for the flash status controller
// assumes one clock domain and a zero-wait bus slave
`timescale 1ns/1ps

module fsc_ctrl_assertions #(
	parameter int AW = 18,
	parameter int DW = 16
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// watched outputs
	input wire logic o_hreadyout,
	input wire logic o_hresp,
	input wire logic [AW-1:0] o_addr,
	input wire logic o_dq_oe_n,
	input wire logic o_ce_n,
	input wire logic o_oe_n,
	input wire logic o_we_n
);
	int oe_cnt_reg;
	int we_cnt_reg;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// strobe widths in cycles, cleared while the strobe is high
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			oe_cnt_reg <= 0;
			we_cnt_reg <= 0;
		end else begin
			oe_cnt_reg <= o_oe_n ? 0 : oe_cnt_reg + 1;
			we_cnt_reg <= o_we_n ? 0 : we_cnt_reg + 1;
		end
	end
	// recovery: both strobes stay high before the next pin cycle
	sequence s_recover;
		(o_oe_n && o_we_n)[*8];
	endsequence
	a_bus_zero_wait: assert property (o_hreadyout) else $error("hreadyout low");
	a_bus_okay: assert property (!o_hresp) else $error("error response");
	a_strobe_excl: assert property (o_oe_n || o_we_n) else $error("read and write strobes");
	a_read_released: assert property (!o_oe_n |-> o_dq_oe_n && !o_ce_n)
		else $error("host drives data during read");
	a_write_drives: assert property (!o_we_n |-> !o_dq_oe_n && !o_ce_n)
		else $error("write strobe without data");
	a_read_width: assert property ($rose(o_oe_n) |-> oe_cnt_reg == 32)
		else $error("read strobe width");
	a_write_width: assert property ($rose(o_we_n) |-> we_cnt_reg == 13)
		else $error("write strobe width");
	a_cycle_gap: assert property ($rose(o_oe_n) |-> s_recover)
		else $error("read recovery too short");
	a_addr_steady: assert property (!o_ce_n && !$past(o_ce_n) |-> $stable(o_addr))
		else $error("address moved in cycle");
endmodule

bind fsc_ctrl fsc_ctrl_assertions #(.AW(AW), .DW(DW)) u_fsc_chk (.i_clk(i_clk),
	.i_rst_n(i_rst_n), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_addr(o_addr),
	.o_dq_oe_n(o_dq_oe_n), .o_ce_n(o_ce_n), .o_oe_n(o_oe_n), .o_we_n(o_we_n));

// file: tb/fsc_ctrl_tb_top.sv
// self-checking bench for the flash status controller
// assumes the behavioural flash model stands on the flash pins
`timescale 1ns/1ps
`include "fsc_consts.svh"

module fsc_ctrl_tb_top;
	typedef struct packed {
		logic wr;
		logic [7:0] off;
		logic [31:0] data;
		logic [31:0] exp_rd;
	} fsc_row_t;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h00000000;
	logic [31:0] hrdata, rd, st;
	logic hreadyout, hresp, dq_oe_n, ce_n, oe_n, we_n, rb_low;
	logic [17:0] faddr;
	logic [15:0] dq_out, flash_dq, dq_in;
	int failures = 0;
	int checks_done = 0;
	int w0;
	fsc_row_t rows [10];
	// data bus resolved from both drivers
	assign dq_in = dq_oe_n ? flash_dq : dq_out;
	always #2 i_clk = ~i_clk;

	fsc_ctrl dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
		.i_hready(hreadyout), .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp),
		.i_dq(dq_in), .i_ready_busy_n_out(!rb_low), .o_addr(faddr), .o_dq(dq_out),
		.o_dq_oe_n(dq_oe_n), .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n));
	fsc_flash_model flash (.i_addr(faddr), .i_dq(dq_in), .i_ce_n(ce_n), .i_oe_n(oe_n),
		.i_we_n(we_n), .o_dq(flash_dq), .o_rb_low(rb_low));

	// one single word transfer; waits for hready in both phases
	task automatic bus(input logic wr, input logic [7:0] off, input logic [31:0] d,
			output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h000000, off};
		hwrite <= wr;
		@(posedge i_clk);
		while (hreadyout !== 1'b1) @(posedge i_clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge i_clk);
		while (hreadyout !== 1'b1) @(posedge i_clk);
		r = hrdata;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// start an operation and poll status until busy drops, bounded
	task automatic run_op(input logic [2:0] op, output logic [31:0] s);
		int n;
		n = 0;
		bus(1'b1, `FSC_OFF_CTRL, {29'h0, op}, rd);
		s = 32'h1;
		while (s[0] !== 1'b0 && n < 3000) begin
			bus(1'b0, `FSC_OFF_STATUS, 32'h0, s);
			n++;
		end
		chk({31'h0, s[0]}, 32'h0);
	endtask
	task automatic end_test(input string name);
		$display("test %s done", name);
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// hang guard, well past the expected run length
	initial begin
		#200000;
		failures++;
		finish_test();
	end

	initial begin
		rows[0] = {1'b1, `FSC_OFF_ADDR, 32'hFFFFFFFF, 32'h0};
		rows[1] = {1'b0, `FSC_OFF_ADDR, 32'h0, 32'h0003FFFF};
		rows[2] = {1'b1, `FSC_OFF_WDATA, 32'hFFFFFFFF, 32'h0};
		rows[3] = {1'b0, `FSC_OFF_WDATA, 32'h0, 32'h0000FFFF};
		rows[4] = {1'b0, `FSC_OFF_CTRL, 32'h0, 32'h0};
		rows[5] = {1'b1, 8'h20, 32'hFFFFFFFF, 32'h0};
		rows[6] = {1'b0, 8'h20, 32'h0, 32'h0};
		rows[7] = {1'b1, `FSC_OFF_RDATA, 32'hFFFFFFFF, 32'h0};
		rows[8] = {1'b0, `FSC_OFF_RDATA, 32'h0, 32'h0};
		rows[9] = {1'b0, `FSC_OFF_STATUS, 32'h0, 32'h00000010};
		repeat (6) @(posedge i_clk);
		i_rst_n <= 1'b1;
		@(posedge i_clk);
		foreach (rows[i]) begin
			bus(rows[i].wr, rows[i].off, rows[i].data, rd);
			if (!rows[i].wr) chk(rd, rows[i].exp_rd);
		end
		end_test("registers");
		run_op(`FSC_OP_READ, st);
		chk(st & 32'hF, {28'h0, `FSC_RES_DONE, 1'b0});
		chk(32'(faddr), 32'h0003FFFF);
		bus(1'b0, `FSC_OFF_RDATA, 32'h0, rd);
		chk(rd, 32'h00000042);
		w0 = flash.writes;
		run_op(`FSC_OP_WRITE, st);
		chk(st & 32'hF, {28'h0, `FSC_RES_DONE, 1'b0});
		chk(32'(flash.writes), 32'(w0 + 1));
		end_test("single cycles");
		flash.busy_reads = 3;
		run_op(`FSC_OP_POLL, st);
		chk(st & 32'hF, {28'h0, `FSC_RES_PASS, 1'b0});
		// third read is the last busy one and matches the array word, so the re-test passes
		flash.tb1 = 1'b1;
		flash.busy_reads = 3;
		flash.tl = 1'b1;
		run_op(`FSC_OP_POLL, st);
		chk(st & 32'h8F, {24'h0, 4'h8, `FSC_RES_PASS, 1'b0});
		chk(32'(flash.resets), 32'h0);
		flash.busy_reads = 1000;
		flash.tl = 1'b1;
		run_op(`FSC_OP_POLL, st);
		chk(st & 32'h9F, {24'h0, 4'h9, `FSC_RES_FAIL, 1'b0});
		chk(32'(flash.resets), 32'h1);
		flash.susp = 1'b1;
		flash.busy_reads = 3;
		run_op(`FSC_OP_POLL, st);
		chk(st & 32'h1F, {27'h0, 1'b1, `FSC_RES_PASS, 1'b0});
		flash.susp = 1'b0;
		end_test("poll");
		flash.busy_reads = 100000;
		bus(1'b1, `FSC_OFF_CTRL, {29'h0, `FSC_OP_POLL}, rd);
		repeat (100) @(posedge i_clk);
		run_op(`FSC_OP_ABORT, st);
		chk(st & 32'h7F, {24'h0, 4'h6, `FSC_RES_ABORT, 1'b0});
		flash.busy_reads = 10;
		flash.et = 1'b1;
		w0 = flash.writes;
		run_op(`FSC_OP_ERASE_ADD, st);
		chk(st & 32'h30F, {22'h0, 2'h1, 4'h0, `FSC_RES_REJECT, 1'b0});
		chk(32'(flash.writes), 32'(w0));
		flash.busy_reads = 0;
		flash.et = 1'b0;
		run_op(`FSC_OP_ERASE_ADD, st);
		chk(st & 32'h30F, {28'h0, `FSC_RES_PASS, 1'b0});
		flash.et_after = 1'b1;
		flash.et = 1'b0;
		run_op(`FSC_OP_ERASE_ADD, st);
		chk(st & 32'h30F, {22'h0, 2'h2, 4'h0, `FSC_RES_REJECT, 1'b0});
		chk(32'(flash.writes), 32'(w0 + 2));
		end_test("abort and erase");
		i_rst_n <= 1'b0;
		@(posedge i_clk);
		chk({28'h0, ce_n, oe_n, we_n, dq_oe_n}, 32'hF);
		i_rst_n <= 1'b1;
		@(posedge i_clk);
		bus(1'b0, `FSC_OFF_STATUS, 32'h0, st);
		chk(st & 32'hF, 32'h0);
		end_test("reset");
		finish_test();
	end
endmodule

// file: tb/fsc_flash_model.sv
// behavioural flash: status word while an embedded algorithm runs
// assumes the bench sets busy_reads, tl, tb1, susp, et and et_after between operations
`timescale 1ns/1ps

module fsc_flash_model (
	// pins from the controller
	input wire logic [17:0] i_addr,
	input wire logic [15:0] i_dq,
	input wire logic i_ce_n,
	input wire logic i_oe_n,
	input wire logic i_we_n,
	// data and open-drain busy
	output logic [15:0] o_dq,
	output logic o_rb_low
);
	int busy_reads = 0;
	int writes = 0;
	int resets = 0;
	logic tl = 1'b0; // bench raises it for an over-limit or zero-to-one program
	logic susp = 1'b0; // erase suspended: toggle bit one frozen, line released
	logic et = 1'b0;
	logic et_after = 1'b0;
	logic tb1 = 1'b0;
	logic tb2 = 1'b0;
	logic rd_act = 1'b0;
	logic wr_act = 1'b0;
	logic [15:0] wr_data = 16'h0000;
	logic [15:0] last = 16'h0000;
	logic [15:0] word;
	// busy pulls the shared line low from the last write strobe on
	assign o_rb_low = (busy_reads > 0) && !susp;
	// status while busy, array data otherwise; a released bus shows the inverse
	always_comb begin
		word = (busy_reads > 0) ? {9'h000, tb1, tl, 1'b0, et, tb2, 2'h0} : 16'h0042;
		o_dq = (i_ce_n || i_oe_n) ? ~last : word;
	end
	// end of each read or write strobe
	always @(i_ce_n or i_oe_n or i_we_n or i_dq) begin
		if (!i_ce_n && !i_oe_n) begin
			rd_act = 1'b1;
		end else if (rd_act) begin
			rd_act = 1'b0;
			last = word;
			if (busy_reads > 0) begin
				if (!susp) begin
					tb1 = ~tb1;
				end
				tb2 = ~tb2;
				busy_reads = busy_reads - 1;
			end
		end
		if (!i_ce_n && !i_we_n) begin
			wr_act = 1'b1;
			wr_data = i_dq;
		end else if (wr_act) begin
			wr_act = 1'b0;
			writes = writes + 1;
			if (wr_data[7:0] == 8'hF0) begin
				busy_reads = 0;
				tl = 1'b0;
				resets = resets + 1;
			end else if (wr_data[7:0] == 8'h30 && !et) begin
				et = et_after;
				busy_reads = 4; // protected sectors skipped silently
			end
		end
	end
endmodule
